// [rtl/cvt_pkg.sv]
// Operation
// - flag overflow when converted magnitude reaches 2^16, masked or not
// - masked overflow returns infinity carrying the source sign
// - set inexact flag when the half result is not exact
// - masked inexact returns the rounded bounded-exponent result
// - unmasked inexact reported only without unmasked overflow or underflow
// - flush-tiny-to-zero control is ignored; behave as if it were 0
// - subnormal source, its mask set, inexact or tiny unmasked: set three flags
// - feature word: bit 28 vector extension, bit 29 half conversion
// - flag tiny result below 2^-14, plus inexact when inexact
// - immediate bit 2 clear: bits 1:0 pick rounding, else control field
`default_nettype none
package cvt_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_CSR       = 8'h00;
  localparam logic [7:0]  OFS_SRC       = 8'h04;
  localparam logic [7:0]  OFS_IMM       = 8'h08;
  localparam logic [7:0]  OFS_RESULT    = 8'h0C;
  localparam logic [7:0]  OFS_FEATURE   = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h18;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ****************************************
  // control/status field layout
  // ****************************************
  localparam int          FLG_INV       = 0;
  localparam int          FLG_DEN       = 1;
  localparam int          FLG_OVF       = 3;
  localparam int          FLG_TINY      = 4;
  localparam int          FLG_INEX      = 5;
  localparam int          MASK_SHIFT    = 7;
  localparam int          RSEL_LSB      = 13;
  localparam int          FLUSH_BIT     = 15;
  localparam logic [31:0] CSR_RESET     = 32'h0000_1F80;
  localparam logic [31:0] CSR_WMASK     = 32'h0000_FFBF;
  localparam logic [5:0]  FLAGS_ALL     = 6'h3F;
  // ****************************************
  // feature word and immediate
  // ****************************************
  localparam int          FEAT_VEC_BIT  = 28;
  localparam int          FEAT_HALF_BIT = 29;
  localparam int          IMM_MS_BIT    = 2;
  localparam int          RES_FAULT_BIT = 16;
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_FAULT     = 1;
  localparam logic [1:0]  RM_NEAREST    = 2'h0;
  localparam logic [1:0]  RM_DOWN       = 2'h1;
  localparam logic [1:0]  RM_UP         = 2'h2;
  localparam logic [1:0]  RM_TRUNC      = 2'h3;
  // ****************************************
  // number formats
  // ****************************************
  localparam logic signed [9:0] EXP_REBIAS = 10'sh070;
  localparam logic signed [9:0] HEXP_MAX   = 10'sh01F;
  localparam logic [7:0]  SEXP_SPECIAL  = 8'hFF;
  localparam logic [4:0]  HEXP_SPECIAL  = 5'h1F;
  localparam logic [4:0]  SHIFT_MAX     = 5'h19;
  localparam logic [14:0] HALF_INF_MAG  = 15'h7C00;
endpackage
`default_nettype wire

// [rtl/single_to_half_convert.sv]
`timescale 1ns/1ps
`default_nettype none
module single_to_half_convert (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // write address channel
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // write data channel
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // write response channel
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // read address channel
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // read data channel
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // interrupt
  output logic             IRQ
);

  // ****************************************
  // helper functions
  // ****************************************

  // merge written bytes into an old word
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // word-align a bus address
  function automatic logic [7:0] align(input logic [7:0] a);
    return {a[7:2], 2'h0};
  endfunction

  // single to half core: {nan,snan,den,tiny,ovf,inex,half}
  function automatic logic [21:0] convert(input logic [31:0] v,
      input logic [1:0] rm);
    logic              s;
    logic [7:0]        e;
    logic [22:0]       m;
    logic signed [9:0] he;
    logic [4:0]        sh;
    logic [47:0]       ext;
    logic [10:0]       kept;
    logic              g;
    logic              st;
    logic              inc;
    logic              nan;
    logic              snan;
    logic              inf;
    logic              den;
    logic              zero;
    logic              tiny;
    logic              ovf;
    logic              inex;
    logic [15:0]       sum;
    logic [15:0]       h;
    s    = v[31];
    e    = v[30:23];
    m    = v[22:0];
    nan  = (e == cvt_pkg::SEXP_SPECIAL) && (m != 23'h0);
    snan = nan && !m[22];
    inf  = (e == cvt_pkg::SEXP_SPECIAL) && (m == 23'h0);
    den  = (e == 8'h0) && (m != 23'h0);
    zero = (e == 8'h0) && (m == 23'h0);
    he   = $signed({2'h0, e}) - cvt_pkg::EXP_REBIAS;
    // denormalising shift for results below the half normal range
    if (he >= 10'sh001) begin
      sh = 5'h0;
    end else if (he < -10'sh017) begin
      sh = cvt_pkg::SHIFT_MAX;
    end else begin
      sh = 5'(10'sh001 - he);
    end
    ext  = {1'b1, m, 24'h0} >> sh;
    kept = ext[47:37];
    g    = ext[36];
    st   = |ext[35:0];
    if (den) begin
      kept = 11'h0;
      g    = 1'b0;
      st   = 1'b1;
    end
    // increment per rounding mode
    case (rm)
      cvt_pkg::RM_NEAREST: inc = g && (st || kept[0]);
      cvt_pkg::RM_DOWN:    inc = s && (g || st);
      cvt_pkg::RM_UP:      inc = !s && (g || st);
      default:             inc = 1'b0;
    endcase
    sum  = {1'b0, (he >= 10'sh001) ? he[4:0] : 5'h0, kept[9:0]}
           + {15'h0, inc};
    tiny = (he < 10'sh001) && !zero;
    ovf  = !nan && !inf && ((he >= cvt_pkg::HEXP_MAX)
           || (sum[14:10] == cvt_pkg::HEXP_SPECIAL));
    // an overflowing value has no exact half form either
    inex = (g || st || ovf) && !nan && !inf && !zero;
    if (nan) begin
      h = {s, cvt_pkg::HEXP_SPECIAL, 1'b1, m[21:13]};
    end else if (inf || ovf) begin
      h = {s, cvt_pkg::HALF_INF_MAG};
    end else begin
      h = {s, sum[14:0]};
    end
    return {nan, snan, den, tiny, ovf, inex, h};
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic        aw_have_q, aw_have_d;
  logic        w_have_q,  w_have_d;
  logic [7:0]  awaddr_q,  awaddr_d;
  logic [31:0] wdata_q,   wdata_d;
  logic [3:0]  wstrb_q,   wstrb_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        rvalid_q,  rvalid_d;
  logic [31:0] rdata_q,   rdata_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic [31:0] csr_q,     csr_d;
  logic [31:0] src_q,     src_d;
  logic [7:0]  imm_q,     imm_d;
  logic [15:0] res_q,     res_d;
  logic        fault_q,   fault_d;
  logic        go_q,      go_d;
  logic [1:0]  irq_st_q,  irq_st_d;
  logic [1:0]  irq_mk_q,  irq_mk_d;

  // ****************************************
  // conversion datapath
  // ****************************************
  logic [1:0]  rmode;
  logic [21:0] cv;
  logic [5:0]  masks;
  logic [5:0]  new_flags;
  logic        do_write;
  logic        ar_fire;

  // rounding select; flush-tiny-to-zero bit is never consulted
  assign rmode = imm_q[cvt_pkg::IMM_MS_BIT]
                 ? csr_q[cvt_pkg::RSEL_LSB +: 2] : imm_q[1:0];
  assign cv    = convert(src_q, rmode);
  assign masks = csr_q[cvt_pkg::MASK_SHIFT +: 6];

  // flags raised by this conversion
  always_comb begin
    new_flags = 6'h0;
    new_flags[cvt_pkg::FLG_INV]  = cv[20];
    new_flags[cvt_pkg::FLG_DEN]  = cv[19];
    new_flags[cvt_pkg::FLG_OVF]  = cv[17];
    new_flags[cvt_pkg::FLG_TINY] = cv[18];
    // inexact withheld behind an unmasked overflow or underflow
    new_flags[cvt_pkg::FLG_INEX] = cv[16] && !(
        (cv[17] && !masks[cvt_pkg::FLG_OVF]) ||
        (cv[18] && !masks[cvt_pkg::FLG_TINY]));
    // subnormal source with its mask set, and inexact or tiny unmasked, forces three flags
    if (cv[19] && masks[cvt_pkg::FLG_DEN] &&
        (!masks[cvt_pkg::FLG_INEX] || !masks[cvt_pkg::FLG_TINY])) begin
      new_flags[cvt_pkg::FLG_DEN]  = 1'b1;
      new_flags[cvt_pkg::FLG_TINY] = 1'b1;
      new_flags[cvt_pkg::FLG_INEX] = 1'b1;
    end
  end

  // ****************************************
  // bus handshakes
  // ****************************************
  assign S_AXI_AWREADY = !aw_have_q;
  assign S_AXI_WREADY  = !w_have_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign IRQ           = |(irq_st_q & irq_mk_q);
  assign do_write      = aw_have_q && w_have_q && !bvalid_q;
  assign ar_fire       = S_AXI_ARVALID && !rvalid_q;

  // next state of bus, registers and converter
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    csr_d     = csr_q;
    src_d     = src_q;
    imm_d     = imm_q;
    res_d     = res_q;
    fault_d   = fault_q;
    go_d      = 1'b0;
    irq_st_d  = irq_st_q;
    irq_mk_d  = irq_mk_q;
    // capture address and data in either order
    if (S_AXI_AWVALID && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = align(S_AXI_AWADDR);
    end
    if (S_AXI_WVALID && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d  = S_AXI_WDATA;
      wstrb_d  = S_AXI_WSTRB;
    end
    if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
    // register write once both halves are held
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = cvt_pkg::RESP_OKAY;
      if (awaddr_q == cvt_pkg::OFS_CSR) begin
        csr_d = strobe_merge(csr_q, wdata_q, wstrb_q) & cvt_pkg::CSR_WMASK;
      end else if (awaddr_q == cvt_pkg::OFS_SRC) begin
        src_d = strobe_merge(src_q, wdata_q, wstrb_q);
        go_d  = 1'b1;
      end else if (awaddr_q == cvt_pkg::OFS_IMM) begin
        imm_d = wstrb_q[0] ? wdata_q[7:0] : imm_q;
      end else if (awaddr_q == cvt_pkg::OFS_IRQ_MASK) begin
        irq_mk_d = wstrb_q[0] ? wdata_q[1:0] : irq_mk_q;
      end else if (awaddr_q == cvt_pkg::OFS_RESULT ||
                   awaddr_q == cvt_pkg::OFS_FEATURE ||
                   awaddr_q == cvt_pkg::OFS_IRQ_STAT) begin
        bresp_d = cvt_pkg::RESP_OKAY;
      end else begin
        bresp_d = cvt_pkg::RESP_SLVERR;
      end
    end
    if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
    // register read; status of interrupts clears on read
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = cvt_pkg::RESP_OKAY;
      rdata_d  = 32'h0;
      if (align(S_AXI_ARADDR) == cvt_pkg::OFS_CSR) begin
        rdata_d = csr_q;
      end else if (align(S_AXI_ARADDR) == cvt_pkg::OFS_SRC) begin
        rdata_d = src_q;
      end else if (align(S_AXI_ARADDR) == cvt_pkg::OFS_IMM) begin
        rdata_d = {24'h0, imm_q};
      end else if (align(S_AXI_ARADDR) == cvt_pkg::OFS_RESULT) begin
        rdata_d = {15'h0, fault_q, res_q};
      end else if (align(S_AXI_ARADDR) == cvt_pkg::OFS_FEATURE) begin
        rdata_d[cvt_pkg::FEAT_VEC_BIT]  = 1'b1;
        rdata_d[cvt_pkg::FEAT_HALF_BIT] = 1'b1;
      end else if (align(S_AXI_ARADDR) == cvt_pkg::OFS_IRQ_STAT) begin
        rdata_d  = {30'h0, irq_st_q};
        irq_st_d = 2'h0;
      end else if (align(S_AXI_ARADDR) == cvt_pkg::OFS_IRQ_MASK) begin
        rdata_d = {30'h0, irq_mk_q};
      end else begin
        rresp_d = cvt_pkg::RESP_SLVERR;
      end
    end
    // conversion result; new flags win over a same-cycle write
    if (go_q) begin
      res_d   = cv[15:0];
      csr_d[5:0] = csr_d[5:0] | new_flags;
      fault_d = |(new_flags & ~masks);
      irq_st_d[cvt_pkg::IRQ_DONE] = 1'b1;
      if (|(new_flags & ~masks)) begin
        irq_st_d[cvt_pkg::IRQ_FAULT] = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
      csr_q     <= cvt_pkg::CSR_RESET;
      src_q     <= 32'h0;
      imm_q     <= 8'h0;
      res_q     <= 16'h0;
      fault_q   <= 1'b0;
      go_q      <= 1'b0;
      irq_st_q  <= 2'h0;
      irq_mk_q  <= 2'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      csr_q     <= csr_d;
      src_q     <= src_d;
      imm_q     <= imm_d;
      res_q     <= res_d;
      fault_q   <= fault_d;
      go_q      <= go_d;
      irq_st_q  <= irq_st_d;
      irq_mk_q  <= irq_mk_d;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // writes to the control word in this cycle
  logic csr_wr;
  assign csr_wr = do_write && (awaddr_q == cvt_pkg::OFS_CSR);

  chk_ovf_flag_set: assert property (
    go_q && src_q[30:23] >= 8'h8F && src_q[30:23] != 8'hFF
    |=> csr_q[cvt_pkg::FLG_OVF]) else $error("overflow flag missing");
  chk_ovf_inf_result: assert property (
    go_q && cv[17] && masks[cvt_pkg::FLG_OVF]
    |=> res_q == {src_q[31], cvt_pkg::HALF_INF_MAG})
    else $error("masked overflow not infinity");
  chk_inex_flag_set: assert property (
    go_q && cv[16] && !cv[17] && !cv[18]
    |=> csr_q[cvt_pkg::FLG_INEX]) else $error("inexact flag missing");
  chk_rounded_result: assert property (
    go_q && !cv[17] && !cv[18] && !cv[21] && masks[cvt_pkg::FLG_INEX]
    && src_q[30:23] != cvt_pkg::SEXP_SPECIAL && rmode == cvt_pkg::RM_TRUNC
    |=> res_q == {$past(src_q[31]), 5'($past(src_q[30:23]) - 8'h70),
    $past(src_q[22:13])}) else $error("truncated result wrong");
  chk_inex_withheld: assert property (
    go_q && cv[17] && !masks[cvt_pkg::FLG_OVF] && !cv[19]
    |-> !new_flags[cvt_pkg::FLG_INEX])
    else $error("inexact reported with unmasked overflow");
  chk_flush_ignored: assert property (
    go_q && cv[18] && !cv[16] && !cv[19]
    |=> res_q[14:0] != 15'h0) else $error("tiny exact value flushed");
  chk_den_three_flags: assert property (
    go_q && cv[19] && masks[cvt_pkg::FLG_DEN] && !masks[cvt_pkg::FLG_INEX]
    |=> csr_q[cvt_pkg::FLG_DEN] && csr_q[cvt_pkg::FLG_TINY]
    && csr_q[cvt_pkg::FLG_INEX]) else $error("subnormal flags missing");
  chk_feature_bits: assert property (
    ar_fire && align(S_AXI_ARADDR) == cvt_pkg::OFS_FEATURE
    |=> S_AXI_RVALID && S_AXI_RDATA[29:28] == 2'h3)
    else $error("feature bits missing");
  chk_tiny_flag_set: assert property (
    go_q && src_q[30:23] < 8'h71 && src_q[30:0] != 31'h0
    |=> csr_q[cvt_pkg::FLG_TINY]) else $error("tiny flag missing");
  chk_round_select: assert property (
    !imm_q[cvt_pkg::IMM_MS_BIT] |-> rmode == imm_q[1:0])
    else $error("rounding select wrong");
  chk_flags_sticky: assert property (
    !$past(csr_wr) |-> ($past(csr_q[5:0]) & ~csr_q[5:0]) == 6'h0)
    else $error("flag dropped without write");
  chk_write_resp: assert property (
    do_write |=> S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write answer late");

  cov_overflow:  cover property (go_q && cv[17]);
  cov_underflow: cover property (go_q && cv[18] && cv[16]);
  cov_subnormal: cover property (go_q && cv[19]);
  cov_irq:       cover property (IRQ ##1 !IRQ);

endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // clock, reset and bus signals
  // ****************************************
  logic        clk;
  logic        rst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        irq;
  int          error_cnt;
  int          checks;
  logic [1:0]  resp;
  logic [31:0] rd_val;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] RND = 32'h3F80_0001;
  logic [15:0] rnd_exp [4] = '{16'h3C00, 16'h3C00, 16'h3C01, 16'h3C00};

  single_to_half_convert DUT (
    .CORE_CLK(clk), .RST(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .IRQ(irq)
  );

  // free-running 200 MHz clock
  always #2.5 clk = ~clk;

  // ****************************************
  // compare, verdict and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // readiness sampled mid-cycle, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int   n;
    logic aw_t;
    logic w_t;
    logic b_t;
    n   = 0;
    b_t = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b_t && n < 100) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid;
      r    = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    chk({31'h0, b_t}, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int   n;
    logic a_t;
    logic t;
    n = 0;
    t = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!t && n < 100) begin
      @(negedge clk);
      a_t = arvalid && arready;
      t   = rvalid;
      d   = rdata;
      r   = rresp;
      @(posedge clk);
      if (a_t) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    chk({31'h0, t}, 32'h1);
  endtask

  // write expecting an okay answer
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, cvt_pkg::RESP_OKAY});
  endtask

  // read, mask and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk({30'h0, r}, {30'h0, cvt_pkg::RESP_OKAY});
    chk(d & m, exp);
  endtask

  // load a source and check the converted word
  task automatic cvt(input logic [31:0] src, input logic [31:0] exp);
    wok(cvt_pkg::OFS_SRC, src);
    rdc(cvt_pkg::OFS_RESULT, 32'h0001_FFFF, exp);
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 1'b0; rst = 1'b1; awaddr = 8'h00; awvalid = 1'b0;
    wdata = 32'h0; wstrb = 4'hF; wvalid = 1'b0; bready = 1'b0;
    araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    error_cnt = 0; checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values, feature word, unmapped place
    rdc(cvt_pkg::OFS_CSR, ALL, cvt_pkg::CSR_RESET);
    // software confirms support before its first conversion
    rdc(cvt_pkg::OFS_FEATURE, ALL, 32'h3000_0000);
    rd(8'h1C, rd_val, resp);
    chk({30'h0, resp}, {30'h0, cvt_pkg::RESP_SLVERR});
    chk(rd_val, 32'h0);
    wr(8'h1C, 32'h0, resp);
    chk({30'h0, resp}, {30'h0, cvt_pkg::RESP_SLVERR});
    // exact value, interrupt raised and cleared by reading
    wok(cvt_pkg::OFS_IRQ_MASK, 32'h3);
    cvt(32'h3F80_0000, 32'h3C00);
    rdc(cvt_pkg::OFS_CSR, ALL, 32'h1F80);
    chk({31'h0, irq}, 32'h1);
    rdc(cvt_pkg::OFS_IRQ_STAT, ALL, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // every immediate rounding mode on an inexact source
    for (int m = 0; m < 4; m++) begin
      wok(cvt_pkg::OFS_IMM, m);
      cvt(RND, {16'h0, rnd_exp[m]});
    end
    rdc(cvt_pkg::OFS_CSR, ALL, 32'h1FA0);
    // immediate defers to control rounding field (up)
    wok(cvt_pkg::OFS_CSR, 32'h5F80);
    wok(cvt_pkg::OFS_IMM, 32'h4);
    cvt(RND, 32'h3C01);
    rdc(cvt_pkg::OFS_CSR, ALL, 32'h5FA0);
    // largest finite value, then just past it in both signs
    wok(cvt_pkg::OFS_CSR, 32'h1F80);
    wok(cvt_pkg::OFS_IMM, 32'h0);
    cvt(32'h477F_E000, 32'h7BFF);
    rdc(cvt_pkg::OFS_CSR, ALL, 32'h1F80);
    cvt(32'h4780_0000, 32'h7C00);
    rdc(cvt_pkg::OFS_CSR, 32'h8, 32'h8);
    cvt(32'hC780_0000, 32'hFC00);
    // flags survive a later clean conversion
    cvt(32'h3F80_0000, 32'h3C00);
    rdc(cvt_pkg::OFS_CSR, 32'h3F, 32'h28);
    // overflow and inexact unmasked: inexact withheld, fault
    wok(cvt_pkg::OFS_CSR, 32'h0B80);
    cvt(32'h4780_0000, 32'h1_7C00);
    rdc(cvt_pkg::OFS_CSR, 32'h3F, 32'h08);
    rdc(cvt_pkg::OFS_IRQ_STAT, ALL, 32'h3);
    // subnormal source with inexact unmasked
    wok(cvt_pkg::OFS_CSR, 32'h0F80);
    cvt(32'h0000_0001, 32'h1_0000);
    rdc(cvt_pkg::OFS_CSR, 32'h3F, 32'h32);
    // tiny exact result with flush control set
    wok(cvt_pkg::OFS_CSR, 32'h9F80);
    cvt(32'h3580_0000, 32'h0010);
    rdc(cvt_pkg::OFS_CSR, ALL, 32'h9F90);
    // masked interrupt stays low
    rdc(cvt_pkg::OFS_IRQ_STAT, ALL, 32'h3);
    wok(cvt_pkg::OFS_IRQ_MASK, 32'h0);
    cvt(32'h3F80_0000, 32'h3C00);
    chk({31'h0, irq}, 32'h0);
    rdc(cvt_pkg::OFS_IRQ_MASK, ALL, 32'h0);
    // tiny inexact result, then signalling and quiet not-a-number
    wok(cvt_pkg::OFS_CSR, 32'h1F80);
    cvt(32'h3580_0001, 32'h0010);
    rdc(cvt_pkg::OFS_CSR, 32'h3F, 32'h30);
    cvt(32'h7F80_0001, 32'h7E00);
    cvt(32'hFFC0_0000, 32'hFE00);
    rdc(cvt_pkg::OFS_CSR, 32'h3F, 32'h31);
    stop_test();
  end
endmodule
`default_nettype wire
